// ==== hw/itc_defs.svh ====
// Register map, field positions and command codes of the I2C target unit
// Assumes inclusion by bare name; byte address of a register is four times its index
// Functional notes
// [RL1] Finish command: ack then wait start
// [RL2] Response after address: ack, receive or data
// [RL3] Response after data: ack/receive or send byte
// [RL4] Ack choice and command apply together; idle inert
// [RL5] Shift access or command clears status flags
// [RL6] Data flag set on byte done or collision
// [RL7] Data flag cleared by one, shift access, command
// [RL8] Address/stop flag on match or stop; same clears
// [RL9] Hold SCL low while interrupt flag set; code holds it only in ST_HOLD_ADDR and ST_HOLD_DATA
// [RL10] Keep last received acknowledge, one means NACK
// [RL11] Collision flag; then never drive SDA low
// [RL12] NACK collision sets address/stop flag; code sets it only after the address, and the data flag after a data byte
// [RL13] Collision flag cleared by one or start
// [RL14] Bus error on illegal start or stop
// [RL15] Bus errors need controller enable, fast clock
// [RL16] Direction bit from last address packet
// [RL17] Source bit: zero stop, one address
// [RL18] Ack choice sent on shift access or command
// [RL19] Command field always reads zero
// [RL20] Own address bits 7:1, bit 0 general call
// [RL21] Stop sets flag only with stop enable
// [RL22] Reserved command behaves like idle command
`ifndef ITC_DEFS_SVH
`define ITC_DEFS_SVH

`define ITC_BYTE_ADDR(i)   {(i), 2'b00}
`define ITC_IDX_CTLR_ONE   6'h03
`define ITC_IDX_CTL_ONE    6'h09
`define ITC_IDX_CTL_TWO    6'h0A
`define ITC_IDX_FLAGS      6'h0B
`define ITC_IDX_OWN_ID     6'h0C
`define ITC_IDX_SHIFT      6'h0D

`define ITC_CTLR_ENABLE    0
`define ITC_C1_ENABLE      0
`define ITC_C1_STOP_EN     5
`define ITC_C2_ACK         2
`define ITC_C2_CMD_HI      1
`define ITC_C2_CMD_LO      0

`define ITC_FL_DATA        7
`define ITC_FL_ADDR_STOP   6
`define ITC_FL_SCL_HOLD    5
`define ITC_FL_RX_ACK      4
`define ITC_FL_CLASH       3
`define ITC_FL_BUS_ERR     2
`define ITC_FL_WAY         1
`define ITC_FL_SOURCE      0

`define ITC_CMD_IDLE       2'h0
`define ITC_CMD_RSVD       2'h1
`define ITC_CMD_FINISH     2'h2
`define ITC_CMD_RESP       2'h3

`define ITC_ACK_NACK       1'b1
`define ITC_BYTE_BITS      4'h8
`define ITC_RESET_BYTE     8'h00
`define ITC_MIN_CLK_RATIO  4

`endif

// ==== hw/itc_pkg.sv ====
// Types of the I2C target unit: state encoding and registered state records
// Assumes itc_defs.svh for the numeric constants
package itc_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_HOLD_ADDR,
        ST_ACK_OUT,
        ST_RX,
        ST_TX,
        ST_ACK_IN,
        ST_HOLD_DATA,
        ST_WAIT_START
    } itc_state_e;

    typedef struct packed {
        itc_state_e state;
        itc_state_e after;
        logic [3:0] bits;
        logic [7:0] shreg;
        logic [7:0] own_id;
        logic       en;
        logic       stop_en;
        logic       ctlr_en;
        logic       ack_act;
        logic       ack_bit;
        logic       from_addr;
        logic       mine;
        logic       data_flag;
        logic       address_stop_flag;
        logic       received_ack_bit;
        logic       clash_flag;
        logic       bus_error_flag;
        logic       dir;
        logic       ap;
        logic       sda_oe;
        logic       scl_oe;
        logic [7:0] rdata;
    } itc_core_s;

    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic       scl_last;
        logic       sda_last;
    } itc_det_s;

endpackage

// ==== hw/itc_cond_if.sv ====
// Bus condition carrier between the pin detector and the target core
// Assumes both ends run on core_clk_in; pulses last one cycle
`timescale 1ns/1ns
interface itc_cond_if;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;

    modport det (output scl_rise, output scl_fall, output start, output stop, output sda);
    modport tgt (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface

// ==== hw/itc_cond_det.sv ====
// Pin synchroniser and start/stop/edge detector for SCL and SDA
// Assumes scl_in and sda_in are asynchronous wired-AND bus levels
`timescale 1ns/1ns
module itc_cond_det (
    input  wire logic core_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic scl_in,
    input  wire logic sda_in,
    itc_cond_if.det   cond
);
    itc_pkg::itc_det_s q;
    itc_pkg::itc_det_s d;
    logic              scl_s;
    logic              sda_s;

    // Only the second stage is looked at
    assign scl_s = q.scl_sync[1];
    assign sda_s = q.sda_sync[1];

    always_comb begin
        d          = q;
        d.scl_sync = {q.scl_sync[0], scl_in};
        d.sda_sync = {q.sda_sync[0], sda_in};
        d.scl_last = scl_s;
        d.sda_last = sda_s;
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            q <= '1;
        end else begin
            q <= d;
        end
    end

    assign cond.scl_rise = scl_s && !q.scl_last;
    assign cond.scl_fall = !scl_s && q.scl_last;
    assign cond.start    = scl_s && q.scl_last && q.sda_last && !sda_s;
    assign cond.stop     = scl_s && q.scl_last && !q.sda_last && sda_s;
    assign cond.sda      = sda_s;
endmodule // itc_cond_det

// ==== hw/itc_target.sv ====
// I2C target core: register file, command decode, status flags, byte engine
// Assumes a single 100 MHz clock, synchronous reset, plain register port
`timescale 1ns/1ns
`include "itc_defs.svh"
module itc_target #(
    parameter int CLK_PERIOD_NS = 10,
    parameter int SCL_PERIOD_NS = 160
) (
    input  wire logic       core_clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            scl_out,
    output logic            scl_oe_out,
    output logic            sda_out,
    output logic            sda_oe_out
);
    // Bus error detection shares the controller's sampling window
    if (SCL_PERIOD_NS < `ITC_MIN_CLK_RATIO * CLK_PERIOD_NS) begin : g_ratio_check
        $error("SCL too fast for system clock"); // [RL15]
    end

    itc_pkg::itc_core_s q;
    itc_pkg::itc_core_s d;
    itc_cond_if         cond ();

    itc_cond_det u_det (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .scl_in      (scl_in),
        .sda_in      (sda_in),
        .cond        (cond)
    );

    logic       wr_ctlr;
    logic       wr_one;
    logic       wr_two;
    logic       wr_flags;
    logic       wr_own;
    logic       wr_shift;
    logic       rd_shift;
    logic [1:0] cmd;
    logic       cmd_exec;
    logic       cmd_finish;
    logic       sw_clear;
    logic       ack_now;
    logic       held;
    logic       go;
    logic       addr_match;
    logic       mid_byte;
    logic       bus_viol;
    logic [7:0] flags_view;

    assign wr_ctlr  = reg_wr_in && reg_addr_in == `ITC_BYTE_ADDR(`ITC_IDX_CTLR_ONE);
    assign wr_one   = reg_wr_in && reg_addr_in == `ITC_BYTE_ADDR(`ITC_IDX_CTL_ONE);
    assign wr_two   = reg_wr_in && reg_addr_in == `ITC_BYTE_ADDR(`ITC_IDX_CTL_TWO);
    assign wr_flags = reg_wr_in && reg_addr_in == `ITC_BYTE_ADDR(`ITC_IDX_FLAGS);
    assign wr_own   = reg_wr_in && reg_addr_in == `ITC_BYTE_ADDR(`ITC_IDX_OWN_ID);
    assign wr_shift = reg_wr_in && reg_addr_in == `ITC_BYTE_ADDR(`ITC_IDX_SHIFT);
    assign rd_shift = reg_rd_in && reg_addr_in == `ITC_BYTE_ADDR(`ITC_IDX_SHIFT);

    assign cmd        = reg_wdata_in[`ITC_C2_CMD_HI:`ITC_C2_CMD_LO];
    // Idle and reserved codes are not valid commands and only update the ack choice
    assign cmd_exec   = wr_two && (cmd == `ITC_CMD_FINISH || cmd == `ITC_CMD_RESP); // [RL22]
    assign cmd_finish = wr_two && cmd == `ITC_CMD_FINISH;
    assign sw_clear   = cmd_exec || wr_shift || rd_shift; // [RL5]
    // New ack choice counts in the same write as the command
    assign ack_now    = wr_two ? reg_wdata_in[`ITC_C2_ACK] : q.ack_act; // [RL4]

    assign held = (q.state == itc_pkg::ST_HOLD_ADDR) || (q.state == itc_pkg::ST_HOLD_DATA);
    // Releasing a held flag by a written one continues like a response
    assign go   = held && !cmd_finish
                  && ((wr_two && cmd == `ITC_CMD_RESP) || wr_shift || rd_shift // [RL18]
                      || (wr_flags && q.state == itc_pkg::ST_HOLD_ADDR
                          && reg_wdata_in[`ITC_FL_ADDR_STOP])
                      || (wr_flags && q.state == itc_pkg::ST_HOLD_DATA
                          && reg_wdata_in[`ITC_FL_DATA]));

    assign addr_match = (q.shreg[7:1] == q.own_id[7:1])
                        || (q.shreg == `ITC_RESET_BYTE && q.own_id[0]); // [RL20]

    assign mid_byte = (q.state == itc_pkg::ST_ADDR || q.state == itc_pkg::ST_RX
                       || q.state == itc_pkg::ST_TX) && q.bits != 4'h0;
    assign bus_viol = q.ctlr_en
                      && (((cond.start || cond.stop) && mid_byte)
                          || (cond.stop && q.state == itc_pkg::ST_ADDR
                              && q.bits == 4'h0)); // [RL14] [RL15]

    always_comb begin
        flags_view                    = `ITC_RESET_BYTE;
        flags_view[`ITC_FL_DATA]      = q.data_flag;
        flags_view[`ITC_FL_ADDR_STOP] = q.address_stop_flag;
        flags_view[`ITC_FL_SCL_HOLD]  = q.scl_oe; // [RL9]
        flags_view[`ITC_FL_RX_ACK]    = q.received_ack_bit;
        flags_view[`ITC_FL_CLASH]     = q.clash_flag;
        flags_view[`ITC_FL_BUS_ERR]   = q.bus_error_flag;
        flags_view[`ITC_FL_WAY]       = q.dir;
        flags_view[`ITC_FL_SOURCE]    = q.ap;
    end

    always_comb begin
        d       = q;
        d.rdata = `ITC_RESET_BYTE;

        if (reg_rd_in) begin
            case (reg_addr_in)
                `ITC_BYTE_ADDR(`ITC_IDX_CTLR_ONE): d.rdata[`ITC_CTLR_ENABLE] = q.ctlr_en;
                `ITC_BYTE_ADDR(`ITC_IDX_CTL_ONE): begin
                    d.rdata[`ITC_C1_ENABLE]  = q.en;
                    d.rdata[`ITC_C1_STOP_EN] = q.stop_en;
                end
                // Command field is a strobe and always reads zero
                `ITC_BYTE_ADDR(`ITC_IDX_CTL_TWO): d.rdata[`ITC_C2_ACK] = q.ack_act; // [RL19]
                `ITC_BYTE_ADDR(`ITC_IDX_FLAGS):   d.rdata = flags_view;
                `ITC_BYTE_ADDR(`ITC_IDX_OWN_ID):  d.rdata = q.own_id;
                `ITC_BYTE_ADDR(`ITC_IDX_SHIFT):   d.rdata = q.shreg;
                default:                          d.rdata = `ITC_RESET_BYTE;
            endcase
        end

        if (wr_ctlr) begin
            d.ctlr_en = reg_wdata_in[`ITC_CTLR_ENABLE];
        end
        if (wr_one) begin
            d.en      = reg_wdata_in[`ITC_C1_ENABLE];
            d.stop_en = reg_wdata_in[`ITC_C1_STOP_EN];
        end
        if (wr_two) begin
            d.ack_act = reg_wdata_in[`ITC_C2_ACK]; // [RL4]
        end
        if (wr_own) begin
            d.own_id = reg_wdata_in;
        end
        // Shift register only takes writes while the clock is held
        if (wr_shift && held) begin
            d.shreg = reg_wdata_in;
        end

        // Clears first, so any set below wins in the same cycle
        if (sw_clear) begin
            d.data_flag  = 1'b0; // [RL7]
            d.address_stop_flag = 1'b0; // [RL8]
        end
        if (wr_flags) begin
            if (reg_wdata_in[`ITC_FL_DATA]) begin
                d.data_flag = 1'b0; // [RL7]
            end
            if (reg_wdata_in[`ITC_FL_ADDR_STOP]) begin
                d.address_stop_flag = 1'b0; // [RL8]
            end
            if (reg_wdata_in[`ITC_FL_CLASH]) begin
                d.clash_flag = 1'b0; // [RL13]
            end
            if (reg_wdata_in[`ITC_FL_BUS_ERR]) begin
                d.bus_error_flag = 1'b0; // [RL14]
            end
        end

        if (bus_viol) begin
            d.bus_error_flag = 1'b1; // [RL14]
        end

        if (!q.en) begin
            d.state = itc_pkg::ST_IDLE;
            d.mine  = 1'b0;
        end else if (cond.start) begin
            d.clash_flag  = 1'b0; // [RL13]
            d.state = itc_pkg::ST_ADDR;
            d.bits  = 4'h0;
            d.mine  = 1'b0;
        end else if (cond.stop) begin
            if (q.stop_en && q.mine) begin
                d.address_stop_flag = 1'b1; // [RL21]
                d.ap   = 1'b0; // [RL17]
            end
            d.state = itc_pkg::ST_IDLE;
            d.mine  = 1'b0;
        end else begin
            unique case (q.state)
                itc_pkg::ST_IDLE, itc_pkg::ST_WAIT_START: begin
                    d.state = q.state;
                end
                itc_pkg::ST_ADDR: begin
                    if (cond.scl_rise) begin
                        d.shreg = {q.shreg[6:0], cond.sda};
                        d.bits  = q.bits + 4'h1;
                    end else if (cond.scl_fall && q.bits == `ITC_BYTE_BITS) begin
                        d.bits = 4'h0;
                        if (addr_match) begin
                            d.address_stop_flag  = 1'b1; // [RL8]
                            d.ap    = 1'b1; // [RL17]
                            d.dir   = q.shreg[0]; // [RL16]
                            d.mine  = 1'b1;
                            d.state = itc_pkg::ST_HOLD_ADDR; // [RL9]
                        end else begin
                            d.state = itc_pkg::ST_WAIT_START;
                        end
                    end
                end
                itc_pkg::ST_HOLD_ADDR, itc_pkg::ST_HOLD_DATA: begin
                    d.ack_bit   = ack_now;
                    d.from_addr = q.state == itc_pkg::ST_HOLD_ADDR;
                    d.bits      = 4'h0;
                    if (cmd_finish) begin
                        // Transmit side has no ack of its own to give
                        d.state = q.dir ? itc_pkg::ST_WAIT_START : itc_pkg::ST_ACK_OUT; // [RL1]
                        d.after = itc_pkg::ST_WAIT_START;
                    end else if (go && q.state == itc_pkg::ST_HOLD_ADDR) begin
                        d.state = itc_pkg::ST_ACK_OUT; // [RL2]
                        d.after = q.dir ? itc_pkg::ST_HOLD_DATA : itc_pkg::ST_RX;
                    end else if (go) begin
                        d.state = q.dir ? itc_pkg::ST_TX : itc_pkg::ST_ACK_OUT; // [RL3]
                        d.after = itc_pkg::ST_RX;
                    end
                end
                itc_pkg::ST_ACK_OUT: begin
                    if (cond.scl_rise && q.ack_bit == `ITC_ACK_NACK && !cond.sda) begin
                        d.clash_flag = 1'b1; // [RL11]
                        if (q.from_addr) begin
                            d.address_stop_flag = 1'b1; // [RL12]
                            d.ap   = 1'b1;
                        end
                    end else if (cond.scl_fall) begin
                        d.state = q.after;
                        if (q.after == itc_pkg::ST_HOLD_DATA || (q.clash_flag && !q.from_addr)) begin
                            d.data_flag = 1'b1; // [RL2] [RL6]
                        end
                    end
                end
                itc_pkg::ST_RX: begin
                    if (cond.scl_rise) begin
                        d.shreg = {q.shreg[6:0], cond.sda};
                        d.bits  = q.bits + 4'h1;
                    end else if (cond.scl_fall && q.bits == `ITC_BYTE_BITS) begin
                        d.bits  = 4'h0;
                        d.data_flag   = 1'b1; // [RL6]
                        d.state = itc_pkg::ST_HOLD_DATA;
                    end
                end
                itc_pkg::ST_TX: begin
                    if (cond.scl_rise && q.shreg[7] && !cond.sda) begin
                        d.clash_flag = 1'b1; // [RL11]
                    end else if (cond.scl_fall) begin
                        d.shreg = {q.shreg[6:0], 1'b0};
                        d.bits  = q.bits + 4'h1;
                        if (q.bits == `ITC_BYTE_BITS - 4'h1) begin
                            d.bits  = 4'h0;
                            d.state = itc_pkg::ST_ACK_IN;
                        end
                    end
                end
                itc_pkg::ST_ACK_IN: begin
                    if (cond.scl_rise) begin
                        d.received_ack_bit = cond.sda; // [RL10]
                    end else if (cond.scl_fall) begin
                        d.data_flag   = 1'b1; // [RL6]
                        d.state = itc_pkg::ST_HOLD_DATA;
                    end
                end
                default: begin
                    d.state = itc_pkg::ST_IDLE;
                end
            endcase
        end

        // A collision keeps the data and ack drivers off until a start or a written one clears the flag
        d.sda_oe = !d.clash_flag
                   && ((d.state == itc_pkg::ST_ACK_OUT && d.ack_bit != `ITC_ACK_NACK)
                       || (d.state == itc_pkg::ST_TX && !d.shreg[7])); // [RL11]
        d.scl_oe = (d.state == itc_pkg::ST_HOLD_ADDR && d.address_stop_flag)
                   || (d.state == itc_pkg::ST_HOLD_DATA && d.data_flag); // [RL9]
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata_out = q.rdata;
    assign scl_out       = 1'b0;
    assign sda_out       = 1'b0;
    assign scl_oe_out    = q.scl_oe;
    assign sda_oe_out    = q.sda_oe;

    cmd_reads_zero_a: assert property ( // [RL19]
        @(posedge core_clk_in) disable iff (sys_rst_in)
        reg_rd_in && reg_addr_in == `ITC_BYTE_ADDR(`ITC_IDX_CTL_TWO)
        |=> reg_rdata_out[1:0] == 2'b00 && reg_rdata_out[2] == $past(q.ack_act))
        else $error("command field did not read zero");

    hold_drives_scl_a: assert property ( // [RL9]
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (q.state == itc_pkg::ST_HOLD_DATA && q.data_flag) |-> scl_oe_out)
        else $error("scl not held while data flag set");

    clash_quiet_sda_a: assert property ( // [RL11]
        @(posedge core_clk_in) disable iff (sys_rst_in)
        q.clash_flag |-> !sda_oe_out)
        else $error("sda driven low after collision");

    start_clears_clash_a: assert property ( // [RL13]
        @(posedge core_clk_in) disable iff (sys_rst_in)
        cond.start && q.en |=> !q.clash_flag && q.state == itc_pkg::ST_ADDR)
        else $error("start did not clear collision flag");

    shift_clears_flags_a: assert property ( // [RL7]
        @(posedge core_clk_in) disable iff (sys_rst_in)
        rd_shift && !cond.scl_rise && !cond.scl_fall && !cond.stop && !cond.start
        |=> !q.data_flag && !q.address_stop_flag)
        else $error("shift access left a flag set");

    idle_cmd_inert_a: assert property ( // [RL22]
        @(posedge core_clk_in) disable iff (sys_rst_in)
        wr_two && (cmd == `ITC_CMD_IDLE || cmd == `ITC_CMD_RSVD) && held && !wr_flags
        && !cond.start && !cond.stop
        |=> $stable(q.state) && $stable(q.data_flag) && $stable(q.address_stop_flag))
        else $error("idle command changed state");

    stop_source_a: assert property ( // [RL17]
        @(posedge core_clk_in) disable iff (sys_rst_in)
        $rose(q.address_stop_flag) && !q.ap |-> $past(cond.stop) && $past(q.stop_en))
        else $error("stop source without enabled stop");

    bus_err_gate_a: assert property ( // [RL15]
        @(posedge core_clk_in) disable iff (sys_rst_in)
        $rose(q.bus_error_flag) |-> $past(q.ctlr_en) && ($past(cond.start) || $past(cond.stop)))
        else $error("bus error without controller enable");

    way_from_addr_a: assert property ( // [RL16]
        @(posedge core_clk_in) disable iff (sys_rst_in)
        $rose(q.address_stop_flag) && q.ap && q.state == itc_pkg::ST_HOLD_ADDR
        |-> q.dir == q.shreg[0] ##1 scl_oe_out)
        else $error("direction bit not from address packet");
endmodule // itc_target

// ==== verif/itc_ctrl_model.sv ====
// Behavioural I2C bus controller that only ever releases or pulls SCL and SDA low
// Assumes the bench forms the wired-AND bus levels and returns them on scl_in/sda_in
`timescale 1ns/1ns
module itc_ctrl_model (
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_out,
    output logic      stuck_out
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
        stuck_out = 1'b0;
    end
    // Waits out clock stretching, but gives up after 20 us
    task automatic rise();
        #40 scl_out = 1'b1;
        for (int i = 0; i < 2000 && scl_in !== 1'b1; i++) #10;
        stuck_out = stuck_out | (scl_in !== 1'b1);
    endtask
    task automatic clk_bit(input logic b, output logic s);
        sda_out = b;
        rise();
        #40 s = sda_in;
        #40 scl_out = 1'b0;
        #40;
    endtask
    task automatic start_cond();
        sda_out = 1'b0;
        #80 scl_out = 1'b0;
        #40;
    endtask
    task automatic stop_cond();
        sda_out = 1'b0;
        rise();
        #80 sda_out = 1'b1;
        #80;
    endtask
    // Target answer is returned in ack
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(v[i], s);
        clk_bit(1'b1, ack);
    endtask
    task automatic get_byte(input logic nack, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, v[i]);
        clk_bit(nack, s);
    endtask
endmodule // itc_ctrl_model

// ==== verif/itc_target_bench.sv ====
// Self-checking bench for the I2C target unit: register port and bus transfers
// Assumes itc_ctrl_model as the bus controller; wired-AND bus formed here
`timescale 1ns/1ns
module itc_target_bench;
    logic       clk, rst, wr, rd, a0, a1;
    logic [7:0] addr, wdata, f, d;
    wire  [7:0] rdata;
    wire        scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda, stuck;
    wire        scl = m_scl & (scl_oe ? scl_o : 1'b1);
    wire        sda = m_sda & (sda_oe ? sda_o : 1'b1);
    int         miscompares = 0;
    int         check_count = 0;

    itc_target #(.CLK_PERIOD_NS(10), .SCL_PERIOD_NS(160)) u_dut (
        .core_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .scl_in(scl), .sda_in(sda),
        .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_out(sda_o), .sda_oe_out(sda_oe));
    itc_ctrl_model u_ctrl (.scl_in(scl), .sda_in(sda), .scl_out(m_scl), .sda_out(m_sda),
        .stuck_out(stuck));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", n, exp, seen);
            miscompares++;
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    // Polls the flag register; a flag that never comes ends the run
    task automatic wait_flag(input logic [7:0] m, output logic [7:0] v);
        v = 8'h00;
        for (int i = 0; i < 3000 && (v & m) === 8'h00; i++) rd_reg(8'h2C, v);
        if ((v & m) === 8'h00) begin
            $display("Error flag wait expected %h seen %h", m, v);
            miscompares++;
            final_report();
        end
    endtask

    initial begin
        #900_000;
        $display("Error watchdog expected done seen hang");
        miscompares++;
        final_report();
    end

    initial begin
        {addr, wdata, wr, rd, rst} = {8'h00, 8'h00, 1'b0, 1'b0, 1'b1};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_reg(8'h2C, f); check("flags reset", f, 8'h00);
        rd_reg(8'h30, f); check("own id reset", f, 8'h00);
        rd_reg(8'h50, f); check("unmapped", f, 8'h00);
        wr_reg(8'h30, 8'h84);
        rd_reg(8'h30, f); check("own id", f, 8'h84);
        wr_reg(8'h28, 8'h05);
        rd_reg(8'h28, f); check("ctl two", f, 8'h04);
        wr_reg(8'h28, 8'h00);
        wr_reg(8'h24, 8'h21);
        $display("test registers done");
        fork
            begin
                u_ctrl.start_cond();
                u_ctrl.put_byte(8'h84, a0);
                u_ctrl.put_byte(8'hA5, a1);
                u_ctrl.stop_cond();
            end
            begin
                wait_flag(8'h40, f); check("addr flags", f, 8'h61);
                wr_reg(8'h28, 8'h03);
                wait_flag(8'h80, f); check("rx flags", f, 8'hA1);
                wr_reg(8'h28, 8'h04);
                rd_reg(8'h2C, f); check("idle cmd", f, 8'hA1);
                rd_reg(8'h34, f); check("rx byte", f, 8'hA5);
                wait_flag(8'h40, f); check("stop flags", f & 8'hDF, 8'h40);
            end
        join
        check("addr ack", {7'h00, a0}, 8'h00);
        check("data nack", {7'h00, a1}, 8'h01);
        wr_reg(8'h2C, 8'h40);
        rd_reg(8'h2C, f); check("w1c", f, 8'h00);
        wr_reg(8'h28, 8'h00);
        $display("test write transfer done");
        fork
            begin
                u_ctrl.start_cond();
                u_ctrl.put_byte(8'h85, a0);
                u_ctrl.get_byte(1'b1, d);
                u_ctrl.stop_cond();
            end
            begin
                wait_flag(8'h40, f); check("read addr", f, 8'h63);
                wr_reg(8'h28, 8'h03);
                wait_flag(8'h80, f); check("tx ready", f, 8'hA3);
                wr_reg(8'h34, 8'h3C);
                wait_flag(8'h80, f); check("tx done", f, 8'hB3);
                check("scl held", {7'h00, scl_oe}, 8'h01);
                wr_reg(8'h28, 8'h02);
                rd_reg(8'h2C, f); check("finish", f, 8'h13);
                wait_flag(8'h40, f); check("read stop", f & 8'hDF, 8'h52);
            end
        join
        check("tx byte", d, 8'h3C);
        check("read addr ack", {7'h00, a0}, 8'h00);
        $display("test read transfer done");
        wr_reg(8'h2C, 8'h40);
        // Controller pulls SDA low in the ack slot while the target sends NACK
        d = 8'h84;
        fork
            begin
                u_ctrl.start_cond();
                for (int i = 7; i >= 0; i--) u_ctrl.clk_bit(d[i], a1);
                u_ctrl.clk_bit(1'b0, a1);
                u_ctrl.stop_cond();
            end
            begin
                wait_flag(8'h40, f); check("nack addr", f, 8'h71);
                wr_reg(8'h28, 8'h07);
                wait_flag(8'h08, f); check("nack clash", f & 8'h49, 8'h49);
            end
        join
        rd_reg(8'h2C, f); check("clash kept", f & 8'h08, 8'h08);
        wr_reg(8'h2C, 8'h40);
        $display("test collision done");
        wr_reg(8'h0C, 8'h01);
        u_ctrl.start_cond();
        u_ctrl.stop_cond();
        rd_reg(8'h2C, f); check("bus error", f & 8'h0C, 8'h04);
        wr_reg(8'h28, 8'h01);
        rd_reg(8'h2C, f); check("reserved cmd", f & 8'hC4, 8'h04);
        wr_reg(8'h2C, 8'h04);
        rd_reg(8'h2C, f); check("bus error w1c", f & 8'h04, 8'h00);
        check("bus free", {7'h00, stuck}, 8'h00);
        $display("test bus error done");
        final_report();
    end
endmodule // itc_target_bench
